// file: rtl/ilpc_pkg.sv
/*
  Shared constants for the interleaved LVDS pin control block: widths,
  synchroniser pin positions, configuration bit layout and reset values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ilpc_pkg;
  localparam int SAMPLE_W   = 16;
  localparam int PAIR_N     = SAMPLE_W / 2;
  localparam int CONV_W     = SAMPLE_W + 1;
  localparam int WORD_W     = SAMPLE_W + 1;
  localparam int OVR_BIT    = SAMPLE_W;
  localparam int FIFO_DEPTH = 16;

  // Positions of the asynchronous pins in the synchroniser vector
  localparam int PIN_EXT   = 0;
  localparam int PIN_DITH  = 1;
  localparam int PIN_SWING = 2;
  localparam int PIN_LVDS  = 3;
  localparam int PIN_POWER_DOWN_PIN  = 4;
  localparam int PIN_OEN   = 5;
  localparam int PIN_CSN   = 6;
  localparam int PIN_SCLK  = 7;
  localparam int PIN_SDIO  = 8;
  localparam int PIN_SYNC  = 9;
  localparam int PIN_SLAVE = 10;
  localparam int PIN_SMP   = 11;
  localparam int PIN_N     = 12;
  // Active-low pins rest high so reset does not look like a select
  localparam logic [PIN_N-1:0] PINS_RESET = 12'h060;

  // Serial configuration byte layout
  localparam int CFG_W          = 8;
  localparam int CFG_DITHER_BIT = 0;
  localparam int CFG_SWING_BIT  = 1;
  localparam int CFG_LVDS_BIT   = 2;
  localparam int CFG_FORMAT_BIT = 3;
  localparam int CFG_DCS_BIT    = 4;
  localparam int CFG_STBY_BIT   = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
  localparam logic [3:0]       BITS_FULL = 4'h8;

  // Full-scale limits of the converted value and saturated codes
  localparam logic signed [CONV_W-1:0] FS_MAX = 17'sh07FFF;
  localparam logic signed [CONV_W-1:0] FS_MIN = 17'sh18000;
  localparam logic [SAMPLE_W-1:0]      SAT_POS = 16'h7FFF;
  localparam logic [SAMPLE_W-1:0]      SAT_NEG = 16'h8000;

  typedef enum logic [1:0] {
    ILPC_PH_IDLE = 2'b00,
    ILPC_PH_LOW  = 2'b01,
    ILPC_PH_HIGH = 2'b10
  } ilpc_phase_t;
endpackage

// file: rtl/ilpc_stream_if.sv
/*
  Valid/ready word stream between the pin control top and its FIFO.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface ilpc_stream_if #(
  parameter int W = 17
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: rtl/ilpc_fifo.sv
/*
  Word FIFO with registered read data, valid/ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ilpc_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 16
) (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  ilpc_stream_if.snk  wr,
  ilpc_stream_if.src  rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [AW:0]             cnt;
    logic                    out_valid;
    logic [W-1:0]            out_data;
  } ilpc_fifo_st_t;

  ilpc_fifo_st_t q;
  ilpc_fifo_st_t d;
  logic          push;
  logic          pop;

  assign wr.ready = (q.cnt != (AW+1)'(DEPTH));
  assign rd.valid = q.out_valid;
  assign rd.data  = q.out_data;

  always_comb begin
    d    = q;
    push = wr.valid && wr.ready;
    // Refill the output register when it is empty or being taken
    pop  = (q.cnt != '0) && (!q.out_valid || rd.ready);
    if (rd.ready && q.out_valid) begin
      d.out_valid = 1'b0;
    end
    if (pop) begin
      d.out_valid = 1'b1;
      d.out_data  = q.mem[q.rptr];
      d.rptr      = q.rptr + 1'b1;
    end
    if (push) begin
      d.mem[q.wptr] = wr.data;
      d.wptr        = q.wptr + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_fifo_full_stops:  assert property (q.cnt == (AW+1)'(DEPTH) |-> !wr.ready)
    else $error("fifo accepts while full");
  a_fifo_count_track: assert property (push && !pop |=> q.cnt == $past(q.cnt) + 1'b1)
    else $error("fifo count did not follow a write");
endmodule
`default_nettype wire

// file: rtl/ilpc_top.sv
/*
  Pin control and interleaved LVDS output port of a 16-bit converter.
  Assumes every pin input is asynchronous to MCLK_I and is synchronised here;
  the converter sample clock arrives on SAMPLE_CLK_I and is edge-detected;
  CONV_I/CONV_VALID_I come from logic on MCLK_I.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - External mode: dither pin high turns dither on; serial mode uses serial setting.
// - External mode: reduced swing pin high selects reduced swing outputs.
// - External mode: LVDS select pin high selects LVDS signalling over CMOS.
// - External mode: power-down pin asserted forces power-down.
// - Serial mode: power-down pin means power-down or standby per held setting.
// - Outputs driven only while output enable low; high disables them.
// - Serial clock and data ignored while chip select high.
// - Serial clock pin clocks serial port; in external mode it selects format.
// - Serial data pin carries port data; in external mode selects stabilizer.
// - Sync input acts only in slave mode.
// - Eight pairs carry two adjacent bits; lowest pair carries bits 0 and 1.
// - Highest pair carries bits 14 and 15, ascending order across pairs.
// - Data clock driven as a differential pair beside the data pairs.
module ilpc_top #(
  parameter int FIFO_DEPTH = ilpc_pkg::FIFO_DEPTH
) (
  input  wire logic                          MCLK_I,
  input  wire logic                          NRST_I,
  input  wire logic                          EXT_PIN_MODE_I,
  input  wire logic                          SLAVE_MODE_I,
  input  wire logic                          DITHER_SELECT_I,
  input  wire logic                          REDUCED_SWING_SELECT_I,
  input  wire logic                          LVDS_SELECT_I,
  input  wire logic                          POWER_DOWN_PIN_I,
  input  wire logic                          OUTPUT_ENABLE_N_I,
  input  wire logic                          CHIP_SELECT_N_I,
  input  wire logic                          SERIAL_CLOCK_FORMAT_SELECT_I,
  input  wire logic                          SERIAL_IO_STABILIZER_SELECT_I,
  output logic                               SERIAL_IO_STABILIZER_SELECT_O,
  output logic                               SERIAL_IO_STABILIZER_SELECT_OE_O,
  input  wire logic                          SYNC_I,
  input  wire logic                          SAMPLE_CLK_I,
  input  wire logic [ilpc_pkg::CONV_W-1:0]   CONV_I,
  input  wire logic                          CONV_VALID_I,
  output logic                               CONV_READY_O,
  output logic [ilpc_pkg::PAIR_N-1:0]        DATA_PAIR_P_O,
  output logic [ilpc_pkg::PAIR_N-1:0]        DATA_PAIR_N_O,
  output logic                               DATA_CLOCK_OUT_P_O,
  output logic                               DATA_CLOCK_OUT_N_O,
  output logic                               OVERRANGE_FLAG_P_O,
  output logic                               OVERRANGE_FLAG_N_O,
  output logic                               DRIVE_EN_O,
  output logic                               DITHER_EN_O,
  output logic                               REDUCED_SWING_O,
  output logic                               LVDS_MODE_O,
  output logic                               DATA_FORMAT_SELECT_O,
  output logic                               DUTY_CYCLE_STABILIZER_O,
  output logic                               POWER_DOWN_O,
  output logic                               STANDBY_O,
  output logic                               SYNC_SEEN_O
);
  typedef struct packed {
    logic [ilpc_pkg::PIN_N-1:0]  s1;
    logic [ilpc_pkg::PIN_N-1:0]  s2;
    logic [ilpc_pkg::PIN_N-1:0]  s3;
    logic [ilpc_pkg::CFG_W-1:0]  cfg;
    logic [ilpc_pkg::CFG_W-1:0]  shreg;
    logic [ilpc_pkg::CFG_W-1:0]  outsh;
    logic [3:0]                  bitcnt;
    logic                        sio_o;
    logic                        sio_oe;
    logic                        stage_valid;
    logic [ilpc_pkg::WORD_W-1:0] stage_word;
    logic                        ready;
    logic [ilpc_pkg::WORD_W-1:0] word;
    ilpc_pkg::ilpc_phase_t       phase;
    logic [ilpc_pkg::PAIR_N-1:0] pair_p;
    logic [ilpc_pkg::PAIR_N-1:0] pair_n;
    logic                        dco_p;
    logic                        dco_n;
    logic                        or_p;
    logic                        or_n;
    logic                        drv_en;
    logic                        dither;
    logic                        swing;
    logic                        lvds;
    logic                        fmt;
    logic                        duty_cycle_stabilizer;
    logic                        power_down_pin;
    logic                        stby;
    logic                        sync_seen;
  } ilpc_top_st_t;

  ilpc_top_st_t               q;
  ilpc_top_st_t               d;
  logic [ilpc_pkg::PIN_N-1:0] pin_raw;
  logic                       ext;
  logic                       sclk_rise;
  logic                       sclk_fall;
  logic                       cs_rise;
  logic                       smp_rise;
  logic                       smp_fall;
  logic                       sync_ev;
  logic                       accept;
  logic                       off;
  logic [ilpc_pkg::PAIR_N-1:0] lvl;

  ilpc_stream_if #(.W(ilpc_pkg::WORD_W)) fin ();
  ilpc_stream_if #(.W(ilpc_pkg::WORD_W)) fout ();

  ilpc_fifo #(.W(ilpc_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i   (MCLK_I),
    .rst_n_i (NRST_I),
    .wr      (fin.snk),
    .rd      (fout.src)
  );

  // Saturate to the 16-bit range, then apply offset binary or twos complement
  function automatic logic [ilpc_pkg::SAMPLE_W-1:0] fmt_word(
    input logic signed [ilpc_pkg::CONV_W-1:0] v,
    input logic                               twos
  );
    logic [ilpc_pkg::SAMPLE_W-1:0] s;
    if (v > ilpc_pkg::FS_MAX) begin
      s = ilpc_pkg::SAT_POS;
    end else if (v < ilpc_pkg::FS_MIN) begin
      s = ilpc_pkg::SAT_NEG;
    end else begin
      s = v[ilpc_pkg::SAMPLE_W-1:0];
    end
    return twos ? s : {~s[ilpc_pkg::SAMPLE_W-1], s[ilpc_pkg::SAMPLE_W-2:0]};
  endfunction

  function automatic logic over_fs(input logic signed [ilpc_pkg::CONV_W-1:0] v);
    return (v > ilpc_pkg::FS_MAX) || (v < ilpc_pkg::FS_MIN);
  endfunction

  assign pin_raw = {SAMPLE_CLK_I, SLAVE_MODE_I, SYNC_I, SERIAL_IO_STABILIZER_SELECT_I,
                    SERIAL_CLOCK_FORMAT_SELECT_I, CHIP_SELECT_N_I, OUTPUT_ENABLE_N_I,
                    POWER_DOWN_PIN_I, LVDS_SELECT_I, REDUCED_SWING_SELECT_I,
                    DITHER_SELECT_I, EXT_PIN_MODE_I};

  // Edge detectors look only at the second and third stages
  assign ext       = q.s2[ilpc_pkg::PIN_EXT];
  assign sclk_rise = q.s2[ilpc_pkg::PIN_SCLK] && !q.s3[ilpc_pkg::PIN_SCLK];
  assign sclk_fall = !q.s2[ilpc_pkg::PIN_SCLK] && q.s3[ilpc_pkg::PIN_SCLK];
  assign cs_rise   = q.s2[ilpc_pkg::PIN_CSN] && !q.s3[ilpc_pkg::PIN_CSN];
  assign smp_rise  = q.s2[ilpc_pkg::PIN_SMP] && !q.s3[ilpc_pkg::PIN_SMP];
  assign smp_fall  = !q.s2[ilpc_pkg::PIN_SMP] && q.s3[ilpc_pkg::PIN_SMP];
  assign sync_ev   = q.s2[ilpc_pkg::PIN_SYNC] && !q.s3[ilpc_pkg::PIN_SYNC]
                     && q.s2[ilpc_pkg::PIN_SLAVE];
  assign accept    = CONV_VALID_I && q.ready;

  assign fin.valid  = q.stage_valid;
  assign fin.data   = q.stage_word;
  // The serialiser takes one word per sample clock period
  assign fout.ready = smp_rise;

  always_comb begin
    d    = q;
    d.s1 = pin_raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    lvl  = '0;

    // Serial port: shifting frozen while chip select is high; count and readback clear, a full byte commits on its rise
    if (!ext && !q.s2[ilpc_pkg::PIN_CSN]) begin
      if (sclk_rise && q.bitcnt != ilpc_pkg::BITS_FULL) begin
        d.shreg  = {q.shreg[ilpc_pkg::CFG_W-2:0], q.s2[ilpc_pkg::PIN_SDIO]};
        d.bitcnt = q.bitcnt + 4'h1;
      end
      // After a full byte the pin turns round and returns the old setting
      if (sclk_fall && q.bitcnt == ilpc_pkg::BITS_FULL) begin
        d.sio_oe = 1'b1;
        d.sio_o  = q.outsh[ilpc_pkg::CFG_W-1];
        d.outsh  = {q.outsh[ilpc_pkg::CFG_W-2:0], 1'b0};
      end
    end else begin
      if (!ext && cs_rise && q.bitcnt == ilpc_pkg::BITS_FULL) begin
        d.cfg = q.shreg;
      end
      d.bitcnt = '0;
      d.sio_oe = 1'b0;
      d.sio_o  = 1'b0;
      d.outsh  = q.cfg;
    end

    d.dither = ext ? q.s2[ilpc_pkg::PIN_DITH]  : q.cfg[ilpc_pkg::CFG_DITHER_BIT];
    d.swing  = ext ? q.s2[ilpc_pkg::PIN_SWING] : q.cfg[ilpc_pkg::CFG_SWING_BIT];
    d.lvds   = ext ? q.s2[ilpc_pkg::PIN_LVDS]  : q.cfg[ilpc_pkg::CFG_LVDS_BIT];
    d.fmt    = ext ? q.s2[ilpc_pkg::PIN_SCLK]  : q.cfg[ilpc_pkg::CFG_FORMAT_BIT];
    d.duty_cycle_stabilizer    = ext ? q.s2[ilpc_pkg::PIN_SDIO]  : q.cfg[ilpc_pkg::CFG_DCS_BIT];
    d.power_down_pin   = q.s2[ilpc_pkg::PIN_POWER_DOWN_PIN]
               && (ext || !q.cfg[ilpc_pkg::CFG_STBY_BIT]);
    d.stby   = q.s2[ilpc_pkg::PIN_POWER_DOWN_PIN] && !ext && q.cfg[ilpc_pkg::CFG_STBY_BIT];
    off      = d.power_down_pin || d.stby;
    d.drv_en = !q.s2[ilpc_pkg::PIN_OEN] && !off;

    // Capture stage; ready is registered so it halves throughput, which the
    // sample clock period leaves plenty of room for
    if (fin.valid && fin.ready) begin
      d.stage_valid = 1'b0;
    end
    if (accept) begin
      d.stage_valid = 1'b1;
      d.stage_word  = {over_fs(CONV_I), fmt_word(CONV_I, q.fmt)};
    end
    d.ready = !d.stage_valid && !off;

    // Serialiser: an empty FIFO repeats the previous word
    if (smp_rise) begin
      d.phase = ilpc_pkg::ILPC_PH_LOW;
      if (fout.valid) begin
        d.word = fout.data;
      end
    end else if (smp_fall && q.phase == ilpc_pkg::ILPC_PH_LOW) begin
      d.phase = ilpc_pkg::ILPC_PH_HIGH;
    end
    d.sync_seen = sync_ev;
    if (sync_ev) begin
      d.phase = ilpc_pkg::ILPC_PH_IDLE;
    end

    for (int i = 0; i < ilpc_pkg::PAIR_N; i++) begin
      case (d.phase)
        ilpc_pkg::ILPC_PH_HIGH: lvl[i] = d.word[2*i+1];
        ilpc_pkg::ILPC_PH_LOW:  lvl[i] = d.word[2*i];
        default:                lvl[i] = d.word[2*i];
      endcase
    end
    d.pair_p = d.drv_en ? lvl : '0;
    d.pair_n = d.drv_en ? ~lvl : '0;
    d.dco_p  = d.drv_en && (d.phase == ilpc_pkg::ILPC_PH_LOW);
    d.dco_n  = d.drv_en && (d.phase != ilpc_pkg::ILPC_PH_LOW);
    d.or_p   = d.drv_en && d.word[ilpc_pkg::OVR_BIT];
    d.or_n   = d.drv_en && !d.word[ilpc_pkg::OVR_BIT];
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      q     <= '0;
      q.s1  <= ilpc_pkg::PINS_RESET;
      q.s2  <= ilpc_pkg::PINS_RESET;
      q.s3  <= ilpc_pkg::PINS_RESET;
      q.cfg <= ilpc_pkg::CFG_RESET;
    end else begin
      q <= d;
    end
  end

  assign SERIAL_IO_STABILIZER_SELECT_O    = q.sio_o;
  assign SERIAL_IO_STABILIZER_SELECT_OE_O = q.sio_oe;
  assign CONV_READY_O            = q.ready;
  assign DATA_PAIR_P_O           = q.pair_p;
  assign DATA_PAIR_N_O           = q.pair_n;
  assign DATA_CLOCK_OUT_P_O      = q.dco_p;
  assign DATA_CLOCK_OUT_N_O      = q.dco_n;
  assign OVERRANGE_FLAG_P_O      = q.or_p;
  assign OVERRANGE_FLAG_N_O      = q.or_n;
  assign DRIVE_EN_O              = q.drv_en;
  assign DITHER_EN_O             = q.dither;
  assign REDUCED_SWING_O         = q.swing;
  assign LVDS_MODE_O             = q.lvds;
  assign DATA_FORMAT_SELECT_O    = q.fmt;
  assign DUTY_CYCLE_STABILIZER_O = q.duty_cycle_stabilizer;
  assign POWER_DOWN_O            = q.power_down_pin;
  assign STANDBY_O               = q.stby;
  assign SYNC_SEEN_O             = q.sync_seen;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_low_shown;
    DRIVE_EN_O && DATA_CLOCK_OUT_P_O;
  endsequence
  sequence s_fall_in_low;
    smp_fall && q.phase == ilpc_pkg::ILPC_PH_LOW && !sync_ev;
  endsequence

  a_dither_pin_on: assert property (ext && q.s2[ilpc_pkg::PIN_DITH] |=> DITHER_EN_O)
    else $error("dither pin high in external mode did not enable dither");
  a_swing_serial: assert property (!ext |=> REDUCED_SWING_O
                                   == $past(q.cfg[ilpc_pkg::CFG_SWING_BIT]))
    else $error("reduced swing does not follow serial setting");
  a_lvds_pin_sel: assert property (ext |=> LVDS_MODE_O == $past(q.s2[ilpc_pkg::PIN_LVDS]))
    else $error("LVDS select pin not followed");
  a_power_down_pin_ext_pin: assert property (ext && q.s2[ilpc_pkg::PIN_POWER_DOWN_PIN]
                                   |=> POWER_DOWN_O && !DRIVE_EN_O)
    else $error("power-down pin ignored in external mode");
  a_standby_serial: assert property (!ext && q.s2[ilpc_pkg::PIN_POWER_DOWN_PIN]
                                     && q.cfg[ilpc_pkg::CFG_STBY_BIT]
                                     |=> STANDBY_O && !POWER_DOWN_O)
    else $error("standby selection not honoured");
  a_oe_disables: assert property (q.s2[ilpc_pkg::PIN_OEN]
                                  |=> !DRIVE_EN_O && DATA_PAIR_P_O == '0)
    else $error("outputs driven while output enable high");
  a_cs_ignores: assert property (q.s2[ilpc_pkg::PIN_CSN] |=> $stable(q.shreg))
    else $error("serial shift while chip select high");
  a_sync_master: assert property (!q.s2[ilpc_pkg::PIN_SLAVE] |=> !SYNC_SEEN_O)
    else $error("sync acted on outside slave mode");
  a_low_pair_bits: assert property (s_low_shown |-> DATA_PAIR_P_O[0] == q.word[0])
    else $error("lowest pair does not show bit 0");
  a_high_pair_bits: assert property (s_low_shown |-> DATA_PAIR_P_O[7] == q.word[14])
    else $error("highest pair does not show bit 14");
  a_clock_pair: assert property (DRIVE_EN_O |-> DATA_CLOCK_OUT_N_O != DATA_CLOCK_OUT_P_O)
    else $error("data clock pair not complementary");
  a_high_phase: assert property (s_fall_in_low |=> !DRIVE_EN_O
                                 || (!DATA_CLOCK_OUT_P_O && DATA_PAIR_P_O[0] == q.word[1]))
    else $error("higher bit not shown in low clock phase");
  a_overrange_flag: assert property (accept && over_fs(CONV_I)
                                     |=> q.stage_word[ilpc_pkg::OVR_BIT])
    else $error("overrange not flagged");
endmodule
`default_nettype wire

// file: tb/ilpc_rx_model.sv
/*
  Receiver model: rebuilds each word from the eight interleaved pairs.
  Assumes data changes with the data clock and holds for whole MCLK cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module ilpc_rx_model (
  input  wire logic                        clk_i,
  input  wire logic [ilpc_pkg::PAIR_N-1:0] p_i,
  input  wire logic [ilpc_pkg::PAIR_N-1:0] n_i,
  input  wire logic                        dco_p_i,
  input  wire logic                        dco_n_i,
  input  wire logic                        ovr_i,
  output logic [ilpc_pkg::WORD_W-1:0]      word_o,
  output logic                             strobe_o,
  output logic                             diff_ok_o
);
  logic                        dco_q = 1'b0;
  logic                        ok = 1'b1;
  logic [ilpc_pkg::WORD_W-1:0] w;
  // Both data clock edges are used, so one word spans a whole sample period
  always @(posedge clk_i) begin
    strobe_o <= 1'b0;
    if (dco_p_i && !dco_q) begin
      ok = (n_i === ~p_i) && (dco_n_i === 1'b0);
      for (int i = 0; i < 8; i++) w[2*i] = p_i[i];
      w[16] = ovr_i;
    end
    if (!dco_p_i && dco_q) begin
      ok = ok && (n_i === ~p_i) && (dco_n_i === 1'b1);
      for (int i = 0; i < 8; i++) w[2*i+1] = p_i[i];
      word_o    <= w;
      diff_ok_o <= ok;
      strobe_o  <= 1'b1;
    end
    dco_q <= dco_p_i;
  end
endmodule
`default_nettype wire

// file: tb/tb_interleaved_lvds_pin_control.sv
/*
  Self-checking bench for the pin control top, with a receiver model on the pairs.
  Assumes status outputs settle within six MCLK cycles of a pin change.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_interleaved_lvds_pin_control;
  logic clk, nrst, ext, slave, dith, swing, lvds, pd, oen, csn, sclk, sdio_drv, sync, smp;
  logic cval, watch;
  logic [16:0] conv;
  wire ready, dcop, dcon, ovrp, ovrn, drv, dith_o, swing_o, lvds_o, fmt_o, dcs_o, pdo;
  wire stby_o, sync_o, sdio_o, sdio_oe, rx_stb, rx_ok;
  wire [7:0] p, n;
  wire [16:0] rx_word;
  // The device wins the shared serial pin only while it enables its driver
  wire sdio = sdio_oe ? sdio_o : sdio_drv;
  int error_cnt = 0, total_checks = 0, sync_cnt = 0, refused = 0;
  // Configuration the device should hold; its top bit comes back on readback
  logic [7:0] cfg_exp = ilpc_pkg::CFG_RESET;
  logic [31:0] lfsr = 32'd74389;
  logic [16:0] rxq[$];
  logic [16:0] corner[4] = '{17'h08000, 17'h17FFF, 17'h07FFF, 17'h18000};

  ilpc_top u_ilpc_top (.MCLK_I(clk), .NRST_I(nrst), .EXT_PIN_MODE_I(ext),
    .SLAVE_MODE_I(slave), .DITHER_SELECT_I(dith), .REDUCED_SWING_SELECT_I(swing),
    .LVDS_SELECT_I(lvds), .POWER_DOWN_PIN_I(pd), .OUTPUT_ENABLE_N_I(oen),
    .CHIP_SELECT_N_I(csn), .SERIAL_CLOCK_FORMAT_SELECT_I(sclk),
    .SERIAL_IO_STABILIZER_SELECT_I(sdio), .SERIAL_IO_STABILIZER_SELECT_O(sdio_o),
    .SERIAL_IO_STABILIZER_SELECT_OE_O(sdio_oe), .SYNC_I(sync), .SAMPLE_CLK_I(smp),
    .CONV_I(conv), .CONV_VALID_I(cval), .CONV_READY_O(ready), .DATA_PAIR_P_O(p),
    .DATA_PAIR_N_O(n), .DATA_CLOCK_OUT_P_O(dcop), .DATA_CLOCK_OUT_N_O(dcon),
    .OVERRANGE_FLAG_P_O(ovrp), .OVERRANGE_FLAG_N_O(ovrn), .DRIVE_EN_O(drv),
    .DITHER_EN_O(dith_o), .REDUCED_SWING_O(swing_o), .LVDS_MODE_O(lvds_o),
    .DATA_FORMAT_SELECT_O(fmt_o), .DUTY_CYCLE_STABILIZER_O(dcs_o), .POWER_DOWN_O(pdo),
    .STANDBY_O(stby_o), .SYNC_SEEN_O(sync_o));

  ilpc_rx_model u_ilpc_rx_model (.clk_i(clk), .p_i(p), .n_i(n), .dco_p_i(dcop),
    .dco_n_i(dcon), .ovr_i(ovrp), .word_o(rx_word), .strobe_o(rx_stb), .diff_ok_o(rx_ok));

  task automatic check(string what, logic [16:0] seen, logic [16:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic logic [16:0] exp_word(logic signed [16:0] v, logic twos);
    logic ovr;
    logic [15:0] d;
    ovr = (v > ilpc_pkg::FS_MAX) || (v < ilpc_pkg::FS_MIN);
    d = (v > ilpc_pkg::FS_MAX) ? ilpc_pkg::SAT_POS :
        (v < ilpc_pkg::FS_MIN) ? ilpc_pkg::SAT_NEG : v[15:0];
    return {ovr, twos ? d : d ^ 16'h8000};
  endfunction

  task automatic cyc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Valid stays up between words; the caller drops it after the last one
  task automatic send(logic [16:0] v);
    conv = v;
    cval = 1'b1;
    for (int t = 0; t < 40 && ready !== 1'b1; t++) begin
      // Registered ready always costs one cycle; longer waits mean a full buffer
      if (t > 0) refused++;
      cyc(1);
    end
    check("conv ready", ready, 1'b1);
    cyc(1);
  endtask

  task automatic ser_write(logic [7:0] b, logic cs_high);
    csn = cs_high;
    cyc(4);
    for (int i = 7; i >= 0; i--) begin
      sdio_drv = b[i];
      sclk = 1'b0;
      cyc(4);
      sclk = 1'b1;
      cyc(4);
    end
    sclk = 1'b0;
    cyc(5);
    check("readback enable", sdio_oe, !cs_high);
    check("readback bit", sdio_o, cfg_exp[7] && !cs_high);
    csn = 1'b1;
    cyc(8);
    check("release enable", sdio_oe, 1'b0);
    if (!cs_high) cfg_exp = b;
  endtask

  task automatic pulse_sync(logic s, int exp);
    slave = s;
    cyc(4);
    sync_cnt = 0;
    sync = 1'b1;
    cyc(10);
    sync = 1'b0;
    cyc(10);
    check("sync seen", 17'(sync_cnt), 17'(exp));
  endtask

  always @(posedge clk) begin
    if (sync_o === 1'b1) sync_cnt++;
    if (rx_stb === 1'b1) begin
      rxq.push_back(rx_word);
      if (watch) check("pair complement", rx_ok, 1'b1);
      if (watch) check("overrange pair", ovrn, !ovrp);
    end
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Sample clock runs free at 48 ns with a phase unrelated to MCLK
  initial begin
    smp = 1'b0;
    #7.3;
    forever #24 smp = ~smp;
  end

  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] r;
    logic [16:0] v, old;
    logic [16:0] exq[$];
    logic [7:0] b;
    int skip;
    {nrst, slave, dith, swing, lvds, pd, sclk, sdio_drv, sync, cval, watch} = '0;
    {ext, oen, csn} = 3'b101;
    conv = '0;
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      {dith, swing, lvds, sclk, sdio_drv} = r[4:0];
      cyc(6);
      check("ext status", {dith_o, swing_o, lvds_o, fmt_o, dcs_o}, r[4:0]);
    end
    sclk = 1'b1;
    cyc(12);
    old = rxq[$];
    rxq.delete();
    watch = 1'b1;
    refused = 0;
    // Pushing faster than the sample rate pops fills the buffer until it refuses
    for (int k = 0; k < 32; k++) begin
      v = (k < 4) ? corner[k] : 17'(rnd());
      exq.push_back(exp_word(v, 1'b1));
      send(v);
    end
    cval = 1'b0;
    check("buffer refused", 17'(refused > 0), 1'b1);
    for (int t = 0; t < 2000 && rxq.size() < 44; t++) cyc(1);
    skip = 0;
    while (skip < 10 && rxq[skip] === old) skip++;
    for (int k = 0; k < 32; k++) check("rx word", rxq[skip+k], exq[k]);
    check("drained repeat", rxq[skip+32], exq[31]);
    sclk = 1'b0;
    cyc(6);
    rxq.delete();
    send(17'h00123);
    cval = 1'b0;
    for (int t = 0; t < 500 && rxq.size() < 4; t++) cyc(1);
    check("offset word", rxq[$], exp_word(17'h00123, 1'b0));
    watch = 1'b0;
    oen = 1'b1;
    cyc(6);
    check("disabled", {drv, p, n}, 17'h00000);
    oen = 1'b0;
    pd = 1'b1;
    cyc(6);
    check("power_down_pin ext", {pdo, stby_o, drv, ready}, 4'h8);
    pd = 1'b0;
    {dith, swing, lvds} = 3'b000;
    ext = 1'b0;
    cyc(6);
    for (int k = 0; k < 2; k++) begin
      b = k ? 8'h35 : 8'h8A;
      ser_write(b, 1'b0);
      ser_write(~b, 1'b1);
      check("serial status", {dith_o, swing_o, lvds_o, fmt_o, dcs_o},
            {b[0], b[1], b[2], b[3], b[4]});
      pd = 1'b1;
      cyc(6);
      check("power_down_pin serial", {pdo, stby_o}, {~b[5], b[5]});
      pd = 1'b0;
      cyc(6);
    end
    pulse_sync(1'b0, 0);
    pulse_sync(1'b1, 1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
